//--- core/sba_arbiter.sv
// serial bus arbiter: bit time measurement and bus arbitration
//
// Functional notes
// - two-bit mode field: idle, measure, arbitrate; value 11 reserved.
// - reset clears mode, clock select, all flags and counter bits.
// - lost flag is read-only; writing 0 to upper mode bit clears it.
// - clock select 1 uses half prescaler output, 0 uses bus clock / 4.
// - prescaler runs from bus clock or crystal clock per source select.
// - done flag set when measurement ends; any control write clears it.
// - running flag reads 1 while counting, 0 while stopped.
// - overflow flag set on counter overflow; any control write clears it.
// - control register shows counter msb, cleared by any control write.
// - count register shows low eight counter bits, cleared by control write.
// - mode 00 holds counter at reset and idle.
// - measure, select 0: run between two falling receive edges, then done.
// - measure, select 1: start while receive is low, immediately if so.
// - measure, select 1: stop on next rising receive edge.
// - arbitration mode starts counter on every transmit rising edge.
// - sample receive at 38h or 08h; low there sets lost flag.
// - while lost flag set, transmit pin forced high.
// - transmit low before a low sample resets counter until next rise.
// - counter is nine bits plus an overflow bit.
`timescale 1ns/1ns
module sba_arbiter
  import sba_pkg::*;
#(
  parameter logic [7:0] PRESC_DIV = PRESC_DIV_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // serial lines
  input wire logic rx_pin,
  input wire logic serial_tx_internal,
  output logic tx_pin,
  // clock source
  input wire logic crystal_tick
);

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  sba_bus_t bus;
  logic ctrl_wr;
  logic cfg_wr;

  assign bus = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};

  always_comb begin
    ctrl_wr = 1'b0;
    cfg_wr = 1'b0;
    if (bus.wr && bus.addr == OFS_CTRL) begin
      ctrl_wr = 1'b1;
    end else if (bus.wr && bus.addr == OFS_CFG2) begin
      cfg_wr = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sba_mode_t mode_q, mode_d;
  sba_phase_t phase_q, phase_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic clk_sel_q, clk_sel_d;
  logic psrc_q, psrc_d;
  logic lost_q, lost_d;
  logic done_q, done_d;
  logic ovf_q, ovf_d;
  logic sampled_q, sampled_d;
  logic tx_pin_q, tx_pin_d;
  logic [7:0] rdata_q, rdata_d;
  logic ev_done, ev_ovf, ev_lost;
  logic cnt_tick;
  logic rx_rise, rx_fall, tx_rise, tx_fall;
  logic [CNT_W-1:0] sample_at;
  logic [CNT_W:0] cnt_inc;
  sba_ctrl_t ctrl_view;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  sba_tick_gen #(
    .PRESC_DIV(PRESC_DIV)
  ) u_tick (
    .clk(clk),
    .reset(reset),
    .clk_sel(clk_sel_q),
    .psrc_sel(psrc_q),
    .crystal_tick(crystal_tick),
    .cnt_tick(cnt_tick)
  );

  sba_edge_det #(
    .WIDTH(2),
    .IDLE_LVL(2'h3)
  ) u_edge (
    .clk(clk),
    .reset(reset),
    .line_in({serial_tx_internal, rx_pin}),
    .rise({tx_rise, rx_rise}),
    .fall({tx_fall, rx_fall})
  );

  assign sample_at = clk_sel_q ? SAMPLE_PSC : SAMPLE_BUS;
  // extra top bit is the overflow bit
  assign cnt_inc = {1'b0, cnt_q} + {1'b0, CNT_ONE};

  // ---------------------------------------------------------------
  // counter and flags
  // ---------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    phase_d = phase_q;
    cnt_d = cnt_q;
    clk_sel_d = clk_sel_q;
    psrc_d = psrc_q;
    sampled_d = sampled_q;
    ev_done = 1'b0;
    ev_ovf = 1'b0;
    ev_lost = 1'b0;
    case (mode_q)
      MODE_MEAS: begin
        case (phase_q)
          PH_IDLE: begin
            if (clk_sel_q ? !rx_pin : rx_fall) begin
              phase_d = PH_RUN;
              cnt_d = CNT_RST;
            end
          end
          PH_RUN: begin
            if (clk_sel_q ? rx_rise : rx_fall) begin
              phase_d = PH_STOP;
              ev_done = 1'b1;
            end else if (cnt_tick) begin
              cnt_d = cnt_inc[CNT_W-1:0];
              ev_ovf = cnt_inc[CNT_W];
            end
          end
          PH_STOP: begin
            phase_d = PH_STOP;
          end
          default: begin
            phase_d = PH_IDLE;
          end
        endcase
      end
      MODE_ARB: begin
        if (tx_rise) begin
          phase_d = PH_RUN;
          cnt_d = CNT_RST;
          sampled_d = 1'b0;
        end else if (tx_fall && !lost_q) begin
          phase_d = PH_IDLE;
          cnt_d = CNT_RST;
          sampled_d = 1'b0;
        end else if (phase_q == PH_RUN) begin
          if (cnt_q == sample_at && !sampled_q) begin
            sampled_d = 1'b1;
            ev_lost = !rx_pin;
          end
          if (cnt_tick) begin
            cnt_d = cnt_inc[CNT_W-1:0];
            ev_ovf = cnt_inc[CNT_W];
          end
        end
      end
      default: begin
        // idle and reserved codes keep the counter cleared
        phase_d = PH_IDLE;
        cnt_d = CNT_RST;
        sampled_d = 1'b0;
      end
    endcase
    // software write clears the counter and returns it to idle
    if (ctrl_wr) begin
      mode_d = sba_mode_t'(bus.wdata[BIT_MODE_HI:BIT_MODE_LO]);
      clk_sel_d = bus.wdata[BIT_CLK_SEL];
      phase_d = PH_IDLE;
      cnt_d = CNT_RST;
      sampled_d = 1'b0;
    end
    if (cfg_wr) begin
      psrc_d = bus.wdata[BIT_PSRC];
    end
    // hardware set wins over software clear
    done_d = (done_q && !ctrl_wr) || ev_done;
    ovf_d = (ovf_q && !ctrl_wr) || ev_ovf;
    lost_d = (lost_q && !(ctrl_wr && !bus.wdata[BIT_MODE_HI])) || ev_lost;
    tx_pin_d = serial_tx_internal || lost_d;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mode_q <= MODE_IDLE;
      phase_q <= PH_IDLE;
      cnt_q <= CNT_RST;
      clk_sel_q <= 1'b0;
      psrc_q <= 1'b0;
      lost_q <= 1'b0;
      done_q <= 1'b0;
      ovf_q <= 1'b0;
      sampled_q <= 1'b0;
      tx_pin_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      clk_sel_q <= clk_sel_d;
      psrc_q <= psrc_d;
      lost_q <= lost_d;
      done_q <= done_d;
      ovf_q <= ovf_d;
      sampled_q <= sampled_d;
      tx_pin_q <= tx_pin_d;
    end
  end

  assign tx_pin = tx_pin_q;

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_view = '{
      mode: mode_q,
      lost: lost_q,
      clk_sel: clk_sel_q,
      done: done_q,
      run: (phase_q == PH_RUN),
      ovf: ovf_q,
      msb: cnt_q[CNT_W-1]
    };
    rdata_d = RD_ZERO;
    if (bus.rd && bus.addr == OFS_CTRL) begin
      rdata_d = ctrl_view;
    end else if (bus.rd && bus.addr == OFS_COUNT) begin
      rdata_d = cnt_q[7:0];
    end else if (bus.rd && bus.addr == OFS_CFG2) begin
      rdata_d = {7'h00, psrc_q};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= RD_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_idle_holds: assert property (
    (mode_q == MODE_IDLE && !ctrl_wr) |=> (cnt_q == CNT_RST && phase_q == PH_IDLE))
    else $error("idle mode let the counter move");

  a_wr_clears_cnt: assert property (
    ctrl_wr |=> (cnt_q == CNT_RST && !ctrl_view.run))
    else $error("control write did not clear the counter");

  a_wr_clears_done: assert property (
    (ctrl_wr && !ev_done) |=> !done_q)
    else $error("control write did not clear done flag");

  a_wr_clears_ovf: assert property (
    (ctrl_wr && !ev_ovf) |=> !ovf_q)
    else $error("control write did not clear overflow flag");

  a_lost_clear: assert property (
    (ctrl_wr && !bus.wdata[BIT_MODE_HI] && !ev_lost) |=> !lost_q)
    else $error("lost flag survived clearing write");

  a_tx_forced: assert property (
    lost_q |-> tx_pin_q)
    else $error("transmit pin not forced high while lost");

  a_meas_fall: assert property (
    (mode_q == MODE_MEAS && !clk_sel_q && phase_q == PH_RUN && rx_fall && !ctrl_wr)
    |=> (done_q && phase_q == PH_STOP) ##1 $stable(cnt_q) or ctrl_wr)
    else $error("measurement did not stop on second falling edge");

  a_break_start: assert property (
    (mode_q == MODE_MEAS && clk_sel_q && phase_q == PH_IDLE && !rx_pin && !ctrl_wr)
    |=> ctrl_view.run)
    else $error("low receive line did not start counter");

  a_break_stop: assert property (
    (mode_q == MODE_MEAS && clk_sel_q && phase_q == PH_RUN && rx_rise && !ctrl_wr)
    |=> (!ctrl_view.run && done_q))
    else $error("rising receive edge did not stop counter");

  a_arb_start: assert property (
    (mode_q == MODE_ARB && tx_rise && !ctrl_wr) |=> (ctrl_view.run && cnt_q == CNT_RST))
    else $error("transmit rise did not start arbitration count");

  a_arb_sample: assert property (
    (mode_q == MODE_ARB && phase_q == PH_RUN && cnt_q == sample_at && !sampled_q
      && !rx_pin && !tx_rise && !tx_fall) |=> lost_q)
    else $error("low sample did not set lost flag");

  a_arb_abort: assert property (
    (mode_q == MODE_ARB && tx_fall && !lost_q && !ctrl_wr)
    |=> (!ctrl_view.run && cnt_q == CNT_RST))
    else $error("early transmit low did not reset counter");

  a_div4_rate: assert property (
    (cnt_tick && !clk_sel_q && !$past(clk_sel_q)) |=> (!cnt_tick || clk_sel_q) [*3])
    else $error("bus clock enable faster than one in four");

  a_ovf_hold: assert property (
    (ovf_q && !ctrl_wr) |=> ovf_q)
    else $error("overflow flag dropped without write");

  c_meas_done: cover property (mode_q == MODE_MEAS && ev_done);
  c_arb_lost: cover property (mode_q == MODE_ARB && ev_lost);
  c_arb_abort: cover property (mode_q == MODE_ARB && tx_fall && !lost_q && ctrl_view.run);
  c_overflow: cover property (ev_ovf);

endmodule // sba_arbiter

//--- core/sba_edge_det.sv
// edge detector for synchronous single-bit lines
`timescale 1ns/1ns
module sba_edge_det
  import sba_pkg::*;
#(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] IDLE_LVL = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // lines
  input wire logic [WIDTH-1:0] line_in,
  // edges
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;

  always_comb begin
    prev_d = line_in;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      prev_q <= IDLE_LVL;
    end else begin
      prev_q <= prev_d;
    end
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_edge
    assign rise[i] = line_in[i] & ~prev_q[i];
    assign fall[i] = ~line_in[i] & prev_q[i];
  end

endmodule // sba_edge_det

//--- core/sba_pkg.sv
// package: constants and types of the serial bus arbiter
package sba_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h01;
  localparam logic [7:0] OFS_CFG2 = 8'h02;
  localparam logic [7:0] RD_ZERO = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_CLK_SEL = 4;
  localparam int BIT_PSRC = 0;

  // ---------------------------------------------------------------
  // counter values
  // ---------------------------------------------------------------
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] CNT_RST = 9'h000;
  localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
  localparam logic [CNT_W-1:0] CNT_MAX = 9'h1FF;
  localparam logic [CNT_W-1:0] SAMPLE_BUS = 9'h038;
  localparam logic [CNT_W-1:0] SAMPLE_PSC = 9'h008;

  // ---------------------------------------------------------------
  // clock dividers
  // ---------------------------------------------------------------
  localparam logic [1:0] DIV4_RST = 2'h0;
  localparam logic [1:0] DIV4_STEP = 2'h1;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [7:0] PRESC_RST = 8'h00;
  localparam logic [7:0] PRESC_STEP = 8'h01;
  localparam logic [7:0] PRESC_DIV_DEF = 8'h01;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_MEAS = 2'b01,
    MODE_ARB = 2'b10,
    MODE_RSVD = 2'b11
  } sba_mode_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RUN = 2'b01,
    PH_STOP = 2'b10
  } sba_phase_t;

  // control register image, msb first
  typedef struct packed {
    sba_mode_t mode;
    logic lost;
    logic clk_sel;
    logic done;
    logic run;
    logic ovf;
    logic msb;
  } sba_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sba_bus_t;

endpackage

//--- core/sba_tick_gen.sv
// counter clock enables: bus clock / 4 or prescaler output / 2
`timescale 1ns/1ns
module sba_tick_gen
  import sba_pkg::*;
#(
  parameter logic [7:0] PRESC_DIV = PRESC_DIV_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // selection
  input wire logic clk_sel,
  input wire logic psrc_sel,
  input wire logic crystal_tick,
  // enable out
  output logic cnt_tick
);

  logic [1:0] div4_q, div4_d;
  logic [7:0] presc_q, presc_d;
  logic half_q, half_d;
  logic tick_q, tick_d;
  logic src_tick;
  logic presc_out;

  always_comb begin
    src_tick = psrc_sel ? crystal_tick : 1'b1;
    presc_out = src_tick && (presc_q == PRESC_DIV - PRESC_STEP);
    div4_d = div4_q + DIV4_STEP;
    presc_d = presc_q;
    if (src_tick) begin
      presc_d = presc_out ? PRESC_RST : presc_q + PRESC_STEP;
    end
    half_d = half_q ^ presc_out;
    tick_d = clk_sel ? (presc_out && half_q) : (div4_q == DIV4_LAST);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      div4_q <= DIV4_RST;
      presc_q <= PRESC_RST;
      half_q <= 1'b0;
      tick_q <= 1'b0;
    end else begin
      div4_q <= div4_d;
      presc_q <= presc_d;
      half_q <= half_d;
      tick_q <= tick_d;
    end
  end

  assign cnt_tick = tick_q;

endmodule // sba_tick_gen

//--- sim/sba_arbiter_tb.sv
// testbench: serial bus arbiter against a wired-and bus partner
`timescale 1ns/1ns
module sba_arbiter_tb
  import sba_pkg::*;
;
  logic clk = 1'b0;
  logic reset;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic rx_pin;
  logic serial_tx_internal;
  logic tx_pin;
  logic crystal_tick;
  logic node_low;
  logic [1:0] xtal_cnt;
  logic [7:0] rd_q;
  int cycles = 0;
  int failures = 0;
  int num_checks = 0;

  always #4 clk = ~clk;

  sba_arbiter #(.PRESC_DIV(8'h01)) u_sba_arbiter (
    .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
    .serial_tx_internal(serial_tx_internal), .tx_pin(tx_pin),
    .crystal_tick(crystal_tick)
  );

  sba_bus_node u_sba_bus_node (.tx_pin(tx_pin), .node_low(node_low), .rx_pin(rx_pin));

  // crystal clock enable, one pulse every third cycle
  always @(posedge clk) begin
    xtal_cnt <= (xtal_cnt == 2'h2) ? 2'h0 : xtal_cnt + 2'h1;
    crystal_tick <= (xtal_cnt == 2'h2);
  end

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      conclude();
    end
  end

  // ---------------------------------------------------------------
  // bus and check tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    if (failures == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [8:0] seen, input logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    rd(a, rd_q);
    chk(what, {1'b0, rd_q}, {1'b0, exp});
  endtask

  // count low byte lies in [lo, hi]
  task automatic rng(input logic [7:0] lo, input logic [7:0] hi);
    rd(OFS_COUNT, rd_q);
    chk("count range", {8'h00, (rd_q >= lo && rd_q <= hi)}, 9'h001);
  endtask

  task automatic drv(input logic low, input logic tx);
    @(posedge clk);
    node_low <= low;
    serial_tx_internal <= tx;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rdc("ctrl", OFS_CTRL, 8'h00);
    rdc("count", OFS_COUNT, 8'h00);
    rdc("cfg2", OFS_CFG2, 8'h00);
    rdc("unmapped", 8'h7F, 8'h00);
    chk("tx_pin", {8'h00, tx_pin}, 9'h001);
    wr(OFS_COUNT, 8'hFF);
    rdc("count ro", OFS_COUNT, 8'h00);
    wr(OFS_CTRL, 8'h3F);
    rdc("ctrl ro bits", OFS_CTRL, 8'h10);
  endtask

  task automatic t_idle_modes;
    logic [7:0] m [2];
    m = '{8'h00, 8'hC0};
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, m[i]);
      drv(1'b1, 1'b1);
      drv(1'b0, 1'b1);
      idle(20);
      rdc("ctrl idle", OFS_CTRL, m[i]);
      rdc("count idle", OFS_COUNT, 8'h00);
    end
  endtask

  task automatic t_meas_bus;
    wr(OFS_CTRL, 8'h40);
    drv(1'b1, 1'b1);
    drv(1'b0, 1'b1);
    idle(600);
    rdc("ctrl running", OFS_CTRL, 8'h44);
    idle(596);
    drv(1'b1, 1'b1);
    drv(1'b0, 1'b1);
    idle(4);
    rdc("ctrl done", OFS_CTRL, 8'h49);
    rng(8'h2A, 8'h2E);
    drv(1'b1, 1'b1);
    drv(1'b0, 1'b1);
    idle(40);
    rng(8'h2A, 8'h2E);
    wr(OFS_CTRL, 8'h40);
    rdc("ctrl cleared", OFS_CTRL, 8'h40);
    rdc("count cleared", OFS_COUNT, 8'h00);
    drv(1'b1, 1'b1);
    drv(1'b0, 1'b1);
    idle(2200);
    drv(1'b1, 1'b1);
    drv(1'b0, 1'b1);
    idle(4);
    rdc("ctrl overflow", OFS_CTRL, 8'h4A);
    rng(8'h24, 8'h28);
    wr(OFS_CTRL, 8'h00);
    rdc("ctrl ovf clear", OFS_CTRL, 8'h00);
    rdc("count ovf clear", OFS_COUNT, 8'h00);
  endtask

  task automatic t_meas_psc;
    wr(OFS_CFG2, 8'h01);
    rdc("cfg2", OFS_CFG2, 8'h01);
    drv(1'b1, 1'b1);
    idle(4);
    wr(OFS_CTRL, 8'h50);
    idle(120);
    drv(1'b0, 1'b1);
    idle(6);
    rdc("ctrl break", OFS_CTRL, 8'h58);
    rng(8'h12, 8'h17);
    wr(OFS_CTRL, 8'h00);
  endtask

  task automatic t_arb;
    logic [7:0] ctl;
    int pt;
    for (int sel = 0; sel < 2; sel++) begin
      ctl = (sel == 1) ? 8'h90 : 8'h80;
      pt = (sel == 1) ? 48 : 224;
      drv(1'b0, 1'b0);
      wr(OFS_CTRL, ctl);
      drv(1'b0, 1'b1);
      idle(20);
      drv(1'b0, 1'b0);
      idle(4);
      rdc("ctrl tx low", OFS_CTRL, ctl);
      rdc("count tx low", OFS_COUNT, 8'h00);
      drv(1'b1, 1'b1);
      idle(pt - 16);
      rdc("ctrl before sample", OFS_CTRL, ctl | 8'h04);
      idle(40);
      rdc("ctrl lost", OFS_CTRL, ctl | 8'h24);
      drv(1'b1, 1'b0);
      idle(3);
      #1;
      chk("tx forced", {8'h00, tx_pin}, 9'h001);
      wr(OFS_CTRL, 8'h00);
      idle(3);
      #1;
      chk("tx released", {8'h00, tx_pin}, 9'h000);
      rdc("ctrl lost clear", OFS_CTRL, 8'h00);
      drv(1'b0, 1'b1);
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    serial_tx_internal = 1'b1;
    crystal_tick = 1'b0;
    node_low = 1'b0;
    xtal_cnt = 2'h0;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_idle_modes();
    t_meas_bus();
    t_meas_psc();
    t_arb();
    conclude();
  end
endmodule // sba_arbiter_tb

//--- sim/sba_bus_node.sv
// partner model: other nodes sharing the single-wire serial bus
`timescale 1ns/1ns
module sba_bus_node (
  // our transmit pin
  input wire logic tx_pin,
  // another node driving the bus dominant
  input wire logic node_low,
  // bus level at our receiver
  output logic rx_pin
);
  // open-drain bus with pull-up: low wins
  assign rx_pin = tx_pin & ~node_low;
endmodule // sba_bus_node
